// ==== inc/erds_map.svh ====
// register offsets, descriptor fields and reset values of the rx descriptor engine
`ifndef ERDS_MAP_SVH
`define ERDS_MAP_SVH
// register offsets on the bus
`define ERDS_OFF_CTRL   8'h00
`define ERDS_OFF_BASE   8'h04
`define ERDS_OFF_CUR    8'h08
`define ERDS_OFF_STAT   8'h0c
`define ERDS_OFF_EVT    8'h10
`define ERDS_OFF_EVCLR  8'h14
`define ERDS_OFF_EVEN   8'h18
// control register bits
`define ERDS_CTRL_START 0
`define ERDS_CTRL_COPY  1
// reset values
`define ERDS_RST_COPY   1'b1
`define ERDS_RST_BASE   32'h0000_0000
`define ERDS_RST_EVEN   18'h0_0000
// status word fields
`define ERDS_OWN_BIT    31
`define ERDS_WRAP_BIT   30
`define ERDS_RFE_BIT    27
`define ERDS_FS_WIDTH   10
`define ERDS_FS_MASK    10'h2df
// frame position codes
`define ERDS_POS_MID    2'b00
`define ERDS_POS_END    2'b01
`define ERDS_POS_START  2'b10
`define ERDS_POS_ONE    2'b11
// descriptor layout in memory
`define ERDS_DESC_STRIDE 32'h0000_0010
`define ERDS_LEN_OFF    32'h0000_0004
`define ERDS_ADDR_OFF   32'h0000_0008
`define ERDS_BEAT_BYTES 17'h0_0004
// event register layout
`define ERDS_EV_WIDTH   18
`define ERDS_EV_DONE    16
`define ERDS_EV_STOP    17
// bus responses
`define ERDS_RESP_OKAY  2'b00
`define ERDS_RESP_SLVERR 2'b10
`endif

// ==== inc/erds_pkg.sv ====
// types shared by the rx descriptor engine
package erds_pkg;
    typedef enum logic [5:0] {
        ERDS_IDLE    = 6'b000001,
        ERDS_RD_STAT = 6'b000010,
        ERDS_RD_LEN  = 6'b000100,
        ERDS_RD_ADDR = 6'b001000,
        ERDS_XFER    = 6'b010000,
        ERDS_WB      = 6'b100000
    } erds_state_t;
endpackage

// ==== rtl/erds_event_flags.sv ====
// sticky event bits with enable mask and one level interrupt
`timescale 1ns/1ps
`default_nettype none
module erds_event_flags
    import erds_pkg::*;
#(
    parameter int W = 18
)
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    input  wire logic [W-1:0] en_mask,
    output logic      [W-1:0] status,
    output logic              irq
);
    logic [W-1:0] status_r;
    logic [W-1:0] status_nxt;
    logic         irq_r;
    logic         irq_nxt;

    // set wins over a clear in the same cycle
    always_comb
    begin
        status_nxt = (status_r & ~clr) | set;
        irq_nxt    = |(status_nxt & en_mask);
    end

    // register flags and interrupt
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            status_r <= '0;
            irq_r    <= 1'b0;
        end
        else
        begin
            status_r <= status_nxt;
            irq_r    <= irq_nxt;
        end
    end

    assign status = status_r;
    assign irq    = irq_r;
endmodule
`default_nettype wire

// ==== rtl/erds_axil_slave.sv ====
// axi4-lite slave front end handing single register accesses inward
`timescale 1ns/1ps
`default_nettype none
`include "erds_map.svh"
module erds_axil_slave
    import erds_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             wr_en,
    output logic [7:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_err,
    output logic [7:0]       rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_err
);
    logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic        awready_r, awready_nxt, wready_r, wready_nxt;
    logic [7:0]  addr_r, addr_nxt;
    logic [31:0] data_r, data_nxt;
    logic [3:0]  strb_r, strb_nxt;
    logic        bvalid_r, bvalid_nxt, arready_r, arready_nxt;
    logic        rvalid_r, rvalid_nxt;
    logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    // address and data are caught in either order; the write fires once both are held
    always_comb
    begin
        aw_got_nxt = aw_got_r | (awvalid & awready_r);
        w_got_nxt  = w_got_r | (wvalid & wready_r);
        addr_nxt   = (awvalid & awready_r) ? awaddr : addr_r;
        data_nxt   = (wvalid & wready_r) ? wdata : data_r;
        strb_nxt   = (wvalid & wready_r) ? wstrb : strb_r;
        wr_en      = aw_got_r & w_got_r & ~bvalid_r;
        bvalid_nxt = bvalid_r & ~bready;
        bresp_nxt  = bresp_r;
        if (wr_en)
        begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = wr_err ? `ERDS_RESP_SLVERR : `ERDS_RESP_OKAY;
        end
        awready_nxt = ~aw_got_nxt;
        wready_nxt  = ~w_got_nxt;
    end

    // one read at a time, answered the cycle after it is taken
    always_comb
    begin
        rvalid_nxt = rvalid_r & ~rready;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (arvalid && arready_r)
        begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = rd_data;
            rresp_nxt  = rd_err ? `ERDS_RESP_SLVERR : `ERDS_RESP_OKAY;
        end
        arready_nxt = ~rvalid_nxt;
    end

    // register both channel groups
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            addr_r    <= 8'h00;
            data_r    <= 32'h0000_0000;
            strb_r    <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `ERDS_RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `ERDS_RESP_OKAY;
        end
        else
        begin
            aw_got_r  <= aw_got_nxt;
            w_got_r   <= w_got_nxt;
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            addr_r    <= addr_nxt;
            data_r    <= data_nxt;
            strb_r    <= strb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
        end
    end

    assign awready = awready_r;
    assign wready  = wready_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign arready = arready_r;
    assign rvalid  = rvalid_r;
    assign rdata   = rdata_r;
    assign rresp   = rresp_r;
    assign wr_addr = addr_r;
    assign wr_data = data_r;
    assign wr_strb = strb_r;
    assign rd_addr = araddr;
endmodule
`default_nettype wire

// ==== rtl/erds_rx_desc_engine.sv ====
// receive descriptor engine: fetch, buffer fill and status word write-back
//
// How it works
// - write-back always clears the owned bit 31 of the status word
// - a fetched status word with owned bit 0 stops the engine
// - after a stop, a start request refetches the same descriptor
// - owned bit 1 on fetch: buffer taken, stream beats written into it
// - ring-wrap bit 30 set: next descriptor is the ring base
// - position bits 29:28 written back; 00 mid-frame, 01 frame end
// - summary error bit 27 set when any status bit set, if copy enabled
// - status bits 9,4,3,2,1,0 report errors, mirrored in event register
// - status bits 7 and 6 report multicast and unmatched address
// - a full buffer is written back non-final, then next descriptor
// - frame end written back final, next descriptor fetched, standby
`timescale 1ns/1ps
`default_nettype none
`include "erds_map.svh"
module erds_rx_desc_engine
    import erds_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             mem_req,
    output logic             mem_we,
    output logic [31:0]      mem_addr,
    output logic [31:0]      mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        rx_valid,
    input  wire logic [31:0] rx_data,
    input  wire logic        rx_last,
    input  wire logic [9:0]  rx_status,
    output logic             rx_ready,
    output logic             irq
);
    localparam int EW = `ERDS_EV_WIDTH;

    logic              wr_en, wr_err, rd_err;
    logic [7:0]        wr_addr, rd_addr;
    logic [31:0]       wr_data, rd_data, wmask, wr_val;
    logic [3:0]        wr_strb;
    logic              copy_r, copy_nxt;
    logic [31:0]       base_r, base_nxt;
    logic [EW-1:0]     even_r, even_nxt, ev_set, ev_clr, ev_status;
    logic              start_pulse, base_wr;
    erds_state_t       state_r, state_nxt;
    logic [31:0]       desc_r, desc_nxt, bufa_r, bufa_nxt;
    logic [15:0]       blen_r, blen_nxt, bcnt_r, bcnt_nxt;
    logic              wrap_r, wrap_nxt, first_r, first_nxt;
    logic              flast_r, flast_nxt, run_r, run_nxt;
    logic [9:0]        fstat_r, fstat_nxt, fs_copy;
    logic              req_r, req_nxt, we_r, we_nxt, rdy_r, rdy_nxt;
    logic [31:0]       maddr_r, maddr_nxt, mdata_r, mdata_nxt, wb_word;
    logic [16:0]       fill;
    logic              full;

    // bus front end
    erds_axil_slave u_bus (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_err  (wr_err),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_err  (rd_err)
    );

    // sticky event register, mirrors frame status bits plus done and stop
    erds_event_flags #(.W(EW)) u_evt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (ev_set),
        .clr     (ev_clr),
        .en_mask (even_r),
        .status  (ev_status),
        .irq     (irq)
    );

    // byte-lane mask and write decode
    always_comb
    begin
        wmask  = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
        wr_val = wr_data & wmask;
        wr_err = !(wr_addr inside {`ERDS_OFF_CTRL, `ERDS_OFF_BASE, `ERDS_OFF_CUR,
                                    `ERDS_OFF_STAT, `ERDS_OFF_EVT, `ERDS_OFF_EVCLR,
                                    `ERDS_OFF_EVEN});
        start_pulse = wr_en && wr_addr == `ERDS_OFF_CTRL && wr_val[`ERDS_CTRL_START];
        base_wr  = wr_en && wr_addr == `ERDS_OFF_BASE;
        copy_nxt = copy_r;
        base_nxt = base_r;
        even_nxt = even_r;
        ev_clr   = '0;
        if (wr_en && wr_addr == `ERDS_OFF_CTRL && wr_strb[0])
            copy_nxt = wr_data[`ERDS_CTRL_COPY];
        if (base_wr)
            base_nxt = (base_r & ~wmask) | wr_val;
        if (wr_en && wr_addr == `ERDS_OFF_EVEN)
            even_nxt = (even_r & ~wmask[EW-1:0]) | wr_val[EW-1:0];
        if (wr_en && wr_addr == `ERDS_OFF_EVCLR)
            ev_clr = wr_val[EW-1:0];
    end

    // read decode; the clear register reads as zero
    always_comb
    begin
        rd_err  = 1'b0;
        rd_data = 32'h0000_0000;
        unique case (rd_addr)
            `ERDS_OFF_CTRL:  rd_data = {30'h0, copy_r, 1'b0};
            `ERDS_OFF_BASE:  rd_data = base_r;
            `ERDS_OFF_CUR:   rd_data = desc_r;
            `ERDS_OFF_STAT:  rd_data = {25'h0, state_r, run_r};
            `ERDS_OFF_EVT:   rd_data = {14'h0, ev_status};
            `ERDS_OFF_EVCLR: rd_data = 32'h0000_0000;
            `ERDS_OFF_EVEN:  rd_data = {14'h0, even_r};
            default:         rd_err  = 1'b1;
        endcase
    end

    // register file
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            copy_r <= `ERDS_RST_COPY;
            base_r <= `ERDS_RST_BASE;
            even_r <= `ERDS_RST_EVEN;
        end
        else
        begin
            copy_r <= copy_nxt;
            base_r <= base_nxt;
            even_r <= even_nxt;
        end
    end

    // buffer fill level and write-back word
    always_comb
    begin
        fill    = {1'b0, bcnt_r} + `ERDS_BEAT_BYTES;
        full    = fill >= {1'b0, blen_r};
        fs_copy = copy_r ? (fstat_r & `ERDS_FS_MASK) : 10'h000;
        wb_word = {1'b0,
                   wrap_r,
                   first_r, flast_r,
                   |fs_copy,
                   17'h0_0000, fs_copy};
    end

    // descriptor state machine
    always_comb
    begin
        state_nxt = state_r;
        desc_nxt  = desc_r;
        bufa_nxt  = bufa_r;
        blen_nxt  = blen_r;
        bcnt_nxt  = bcnt_r;
        wrap_nxt  = wrap_r;
        first_nxt = first_r;
        flast_nxt = flast_r;
        run_nxt   = run_r;
        fstat_nxt = fstat_r;
        req_nxt   = req_r;
        we_nxt    = we_r;
        rdy_nxt   = rdy_r;
        maddr_nxt = maddr_r;
        mdata_nxt = mdata_r;
        ev_set    = '0;
        unique case (state_r)
            ERDS_IDLE:
            begin
                if (base_wr)
                    desc_nxt = base_nxt;
                if (start_pulse)
                begin
                    state_nxt = ERDS_RD_STAT;
                    run_nxt   = 1'b1;
                    req_nxt   = 1'b1;
                    we_nxt    = 1'b0;
                    maddr_nxt = desc_r;
                end
            end
            ERDS_RD_STAT:
                if (mem_ack)
                begin
                    if (!mem_rdata[`ERDS_OWN_BIT])
                    begin
                        state_nxt = ERDS_IDLE;
                        run_nxt   = 1'b0;
                        req_nxt   = 1'b0;
                        ev_set[`ERDS_EV_STOP] = 1'b1;
                    end
                    else
                    begin
                        state_nxt = ERDS_RD_LEN;
                        wrap_nxt  = mem_rdata[`ERDS_WRAP_BIT];
                        maddr_nxt = desc_r + `ERDS_LEN_OFF;
                    end
                end
            ERDS_RD_LEN:
                if (mem_ack)
                begin
                    state_nxt = ERDS_RD_ADDR;
                    blen_nxt  = mem_rdata[31:16];
                    maddr_nxt = desc_r + `ERDS_ADDR_OFF;
                end
            ERDS_RD_ADDR:
                if (mem_ack)
                begin
                    state_nxt = ERDS_XFER;
                    bufa_nxt  = mem_rdata;
                    bcnt_nxt  = 16'h0000;
                    req_nxt   = 1'b0;
                    rdy_nxt   = 1'b1;
                end
            ERDS_XFER:
                if (rdy_r && rx_valid)
                begin
                    rdy_nxt   = 1'b0;
                    req_nxt   = 1'b1;
                    we_nxt    = 1'b1;
                    maddr_nxt = bufa_r + {16'h0000, bcnt_r};
                    mdata_nxt = rx_data;
                    flast_nxt = rx_last;
                    fstat_nxt = fstat_r | (rx_status & `ERDS_FS_MASK);
                end
                else if (req_r && mem_ack)
                begin
                    bcnt_nxt = fill[15:0];
                    if (flast_r || full)
                    begin
                        state_nxt = ERDS_WB;
                        maddr_nxt = desc_r;
                        mdata_nxt = wb_word;
                    end
                    else
                    begin
                        req_nxt = 1'b0;
                        rdy_nxt = 1'b1;
                    end
                end
            ERDS_WB:
                if (mem_ack)
                begin
                    desc_nxt  = wrap_r ? base_r : desc_r + `ERDS_DESC_STRIDE;
                    first_nxt = flast_r;
                    flast_nxt = 1'b0;
                    if (flast_r)
                    begin
                        ev_set[9:0] = fstat_r;
                        ev_set[`ERDS_EV_DONE] = 1'b1;
                        fstat_nxt = 10'h000;
                    end
                    state_nxt = ERDS_RD_STAT;
                    we_nxt    = 1'b0;
                    maddr_nxt = wrap_r ? base_r : desc_r + `ERDS_DESC_STRIDE;
                end
        endcase
    end

    // engine registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= ERDS_IDLE;
            desc_r  <= `ERDS_RST_BASE;
            bufa_r  <= 32'h0000_0000;
            blen_r  <= 16'h0000;
            bcnt_r  <= 16'h0000;
            wrap_r  <= 1'b0;
            first_r <= 1'b1;
            flast_r <= 1'b0;
            run_r   <= 1'b0;
            fstat_r <= 10'h000;
            req_r   <= 1'b0;
            we_r    <= 1'b0;
            rdy_r   <= 1'b0;
            maddr_r <= 32'h0000_0000;
            mdata_r <= 32'h0000_0000;
        end
        else
        begin
            state_r <= state_nxt;
            desc_r  <= desc_nxt;
            bufa_r  <= bufa_nxt;
            blen_r  <= blen_nxt;
            bcnt_r  <= bcnt_nxt;
            wrap_r  <= wrap_nxt;
            first_r <= first_nxt;
            flast_r <= flast_nxt;
            run_r   <= run_nxt;
            fstat_r <= fstat_nxt;
            req_r   <= req_nxt;
            we_r    <= we_nxt;
            rdy_r   <= rdy_nxt;
            maddr_r <= maddr_nxt;
            mdata_r <= mdata_nxt;
        end
    end

    assign mem_req   = req_r;
    assign mem_we    = we_r;
    assign mem_addr  = maddr_r;
    assign mem_wdata = mdata_r;
    assign rx_ready  = rdy_r;
endmodule
`default_nettype wire

// ==== testbench/erds_mem_model.sv ====
// behavioural memory on the engine's memory port
`timescale 1ns/1ps
`default_nettype none
module erds_mem_model
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    input  wire logic [3:0]  dly,
    output logic             mem_ack,
    output logic [31:0]      mem_rdata
);
    logic [31:0] m [0:255];
    logic [3:0]  cnt_r;
    // ack after dly waiting cycles; read data only valid with the ack
    always @(posedge aclk)
    begin
        mem_ack   <= 1'b0;
        mem_rdata <= ~mem_rdata; // flips every cycle, so stale data never holds steady
        if (!aresetn)
        begin
            cnt_r     <= 4'h0;
            mem_rdata <= 32'h5a5a_a5a5;
        end
        else if (mem_req && !mem_ack)
        begin
            if (cnt_r >= dly)
            begin
                mem_ack <= 1'b1;
                cnt_r   <= 4'h0;
                if (mem_we)
                    m[mem_addr[9:2]] <= mem_wdata;
                else
                    mem_rdata <= m[mem_addr[9:2]];
            end
            else
                cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/erds_rx_desc_engine_checker.sv ====
// port assertions for the rx descriptor engine
`timescale 1ns/1ps
`default_nettype none
module erds_rx_desc_engine_checker
    import erds_pkg::*;
#(
    parameter logic [31:0] DLIM = 32'h0000_0100 // descriptors live below this
)
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic        mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic        rx_valid,
    input wire logic        rx_ready,
    input wire logic        irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic wb;
    logic sf;
    // descriptor write-back and status fetch completion
    assign wb = mem_req && mem_we && (mem_addr < DLIM);
    assign sf = mem_ack && !mem_we && (mem_addr < DLIM) && (mem_addr[3:0] == 4'h0);
    own_clear_a: assert property (wb |-> !mem_wdata[31])
        else $error("owned bit left set");
    resv_zero_a: assert property (wb |-> mem_wdata[26:10] == 17'h0 && !mem_wdata[8] && !mem_wdata[5])
        else $error("reserved status bit set");
    sum_err_a: assert property (wb |-> mem_wdata[27] == (|mem_wdata[9:0]))
        else $error("summary flag wrong");
    stop_idle_a: assert property (sf && !mem_rdata[31] |=> (!mem_req && !rx_ready) [*4])
        else $error("activity after inactive fetch");
    go_on_a: assert property (sf && mem_rdata[31] |=> ##[0:3] (mem_req && !mem_we && mem_addr[3:0] == 4'h4))
        else $error("no length fetch");
    beat_take_a: assert property (rx_valid && rx_ready |=> !rx_ready)
        else $error("ready held after beat");
    next_fetch_a: assert property (wb && mem_ack |=> ##[0:3] (mem_req && !mem_we && mem_addr[3:0] == 4'h0))
        else $error("no fetch after write-back");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    cover property (sf && !mem_rdata[31]);
    cover property (wb && mem_wdata[29:28] == 2'b10);
    cover property ($rose(irq));
endmodule
bind erds_rx_desc_engine erds_rx_desc_engine_checker erds_rx_desc_engine_checker_inst (
    .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .rx_valid, .rx_ready, .irq);
`default_nettype wire

// ==== testbench/erds_rx_desc_engine_tb.sv ====
// self-checking bench for the rx descriptor engine
`timescale 1ns/1ps
`default_nettype none
`include "erds_map.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module erds_rx_desc_engine_tb
    import erds_pkg::*;
;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, rx_data = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf, dly = 4'h0;
    logic [9:0]  rx_status = 10'h000;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1, rx_valid = 1'b0, rx_last = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        mem_req, mem_we, mem_ack, rx_ready, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, mem_addr, mem_wdata, mem_rdata, d;
    int          err_total = 0, comparisons = 0;
    // 250 MHz clock
    initial forever #2 aclk = ~aclk;
    erds_rx_desc_engine erds_rx_desc_engine_inst (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
        .rx_valid, .rx_data, .rx_last, .rx_status, .rx_ready, .irq);
    erds_mem_model mem_inst (.aclk, .aresetn, .mem_req, .mem_we, .mem_addr, .mem_wdata,
        .dly, .mem_ack, .mem_rdata);
    task automatic give_verdict();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic bail();
        err_total++;
        give_verdict();
    endtask
    // axi4-lite write, both channels offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        int i;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        rs = s_axi_bresp;
        if (i == 50) bail();
    endtask
    // axi4-lite read
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int i;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        v  = s_axi_rdata;
        rs = s_axi_rresp;
        if (i == 50) bail();
    endtask
    // one stream beat, valid held until taken, dropped after the last
    task automatic beat(input logic [31:0] v, input logic l, input logic [9:0] st);
        int i;
        rx_valid  <= 1'b1;
        rx_data   <= v;
        rx_last   <= l;
        rx_status <= st;
        for (i = 0; i < 500; i++)
        begin
            @(posedge aclk);
            if (rx_ready) break;
        end
        if (l) rx_valid <= 1'b0;
        if (i == 500) bail();
    endtask
    // read the event register until bit b is set
    task automatic poll(input int b);
        int i;
        for (i = 0; i < 100; i++)
        begin
            rd(`ERDS_OFF_EVT, d, r);
            if (d[b] === 1'b1) break;
        end
        if (i == 100) bail();
    endtask
    // main sequence: ring of two descriptors, stop, re-arm and restart
    initial
    begin
        mem_inst.m[0] = 32'h8000_0000;
        mem_inst.m[1] = 32'h0008_0000;
        mem_inst.m[2] = 32'h0000_0200;
        mem_inst.m[4] = 32'hc000_0000;
        mem_inst.m[5] = 32'h0010_0000;
        mem_inst.m[6] = 32'h0000_0300;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`ERDS_OFF_CTRL, d, r);
        `CHK("ctrl", 32'h2, d)
        rd(`ERDS_OFF_EVEN, d, r);
        `CHK("even", 32'h0, d)
        rd(8'h40, d, r);
        `CHK("rresp", `ERDS_RESP_SLVERR, r)
        wr(8'h40, 32'h1, r);
        `CHK("bresp", `ERDS_RESP_SLVERR, r)
        wr(`ERDS_OFF_BASE, 32'h0, r);
        wr(`ERDS_OFF_EVEN, 32'h3_ffff, r);
        wr(`ERDS_OFF_CTRL, 32'h3, r);
        beat(32'h1111_0000, 1'b0, 10'h001);
        dly <= 4'h3; // slow memory from here on
        beat(32'h2222_0000, 1'b0, 10'h000);
        beat(32'h3333_0000, 1'b1, 10'h080);
        poll(`ERDS_EV_STOP);
        `CHK("evt", 32'h3_0081, d)
        `CHK("irq", 1'b1, irq)
        `CHK("wb0", 4'h2, mem_inst.m[0][31:28])
        `CHK("wb1", 32'h5800_0081, mem_inst.m[4])
        `CHK("buf", 32'h2222_0000, mem_inst.m[129])
        `CHK("buf", 32'h3333_0000, mem_inst.m[192])
        rd(`ERDS_OFF_CUR, d, r);
        `CHK("cur", 32'h0, d)
        fork
            beat(32'h4444_0000, 1'b1, 10'h204);
            begin
                repeat (20) @(posedge aclk);
                `CHK("stall", 1'b0, rx_ready)
                mem_inst.m[0] = 32'h8000_0000;
                wr(`ERDS_OFF_EVCLR, 32'h3_ffff, r);
                repeat (2) @(posedge aclk);
                `CHK("irq0", 1'b0, irq)
                wr(`ERDS_OFF_CTRL, 32'h1, r);
            end
        join
        poll(`ERDS_EV_DONE);
        `CHK("evt2", 17'h1_0204, d[16:0])
        `CHK("wb2", 32'h3000_0000, mem_inst.m[0])
        give_verdict();
    end
endmodule
`default_nettype wire
